// ==== hw/pbt_pkg.sv ====
package pbt_pkg;

  localparam int PBT_CLK_PERIOD_NS = 10;
  // No-answer limit on a master cycle
  localparam int PBT_TIMEOUT_NS = 8000;
  localparam int PBT_TIMEOUT_CYCLES = PBT_TIMEOUT_NS / PBT_CLK_PERIOD_NS;

  localparam int PBT_DATA_W = 32;
  localparam int PBT_MEM_DEPTH = 1024;

  // Byte-address steps of the burst counter
  localparam logic [23:0] PBT_STEP_BYTE = 24'h000001;
  localparam logic [23:0] PBT_STEP_WORD = 24'h000002;
  localparam logic [23:0] PBT_STEP_LONG = 24'h000004;

  localparam logic PBT_REQUEST_RESET = 1'b1;
  localparam logic PBT_GRANT_RESET = 1'b1;
  localparam logic [31:0] PBT_DATA_PULLUP = 32'hffffffff;

  // Slave-side pin bundle at rest: reset_n, request_n, lower strobe,
  // upper strobe_n, upper byte_n, lower byte_n, longword_n, read,
  // sequential_n, lock_n
  localparam logic [9:0] PBT_SLAVE_CTL_IDLE = 10'h17b;
  // Master-side pin bundle at rest: reset_n, grant_n, ack_n, error_n
  localparam logic [3:0] PBT_MASTER_CTL_IDLE = 4'h7;

  typedef enum logic [1:0] {
    PBT_SL_IDLE = 2'b00,
    PBT_SL_ADDR = 2'b01,
    PBT_SL_RESP = 2'b11,
    PBT_SL_HOLD = 2'b10
  } pbt_slave_state_t;

  typedef enum logic [2:0] {
    PBT_M_IDLE = 3'b000,
    PBT_M_REQ = 3'b001,
    PBT_M_LOWER = 3'b011,
    PBT_M_STROBE = 3'b010,
    PBT_M_RELEASE = 3'b110,
    PBT_M_FINISH = 3'b111,
    PBT_M_DROP = 3'b101
  } pbt_master_state_t;

endpackage

// ==== hw/pbt_bus_if.sv ====
`timescale 1ns/1ns
interface pbt_bus_if;
  logic system_reset_n;
  logic [23:1] m_addr;
  logic m_longword_n;
  logic m_read;
  logic m_sequential_n;
  logic m_lock_n;
  logic m_lower_addr_strobe;
  logic m_upper_addr_strobe_n;
  logic m_upper_byte_strobe_n;
  logic m_lower_byte_strobe_n;
  logic m_ctl_oe;
  logic [31:0] m_data;
  logic m_data_oe;
  logic secondary_bus_request_n;
  logic [31:0] s_data;
  logic s_data_oe;
  logic s_ack_o;
  logic s_ack_oe;
  logic s_data_error_o;
  logic s_data_error_oe;
  logic secondary_bus_grant_n;
  logic [23:1] addr;
  logic longword_n;
  logic read;
  logic sequential_n;
  logic lock_n;
  logic lower_addr_strobe;
  logic upper_addr_strobe_n;
  logic upper_byte_strobe_n;
  logic lower_byte_strobe_n;
  logic [31:0] data;
  logic ack_n;
  logic data_error_n;

  // Pull-ups hold floating lines high; a floating lower strobe reads idle
  assign addr = m_ctl_oe ? m_addr : 23'h7fffff;
  assign longword_n = m_ctl_oe ? m_longword_n : 1'b1;
  assign read = m_ctl_oe ? m_read : 1'b1;
  assign sequential_n = m_ctl_oe ? m_sequential_n : 1'b1;
  assign lock_n = m_ctl_oe ? m_lock_n : 1'b1;
  assign lower_addr_strobe = m_ctl_oe ? m_lower_addr_strobe : 1'b0;
  assign upper_addr_strobe_n = m_ctl_oe ? m_upper_addr_strobe_n : 1'b1;
  assign upper_byte_strobe_n = m_ctl_oe ? m_upper_byte_strobe_n : 1'b1;
  assign lower_byte_strobe_n = m_ctl_oe ? m_lower_byte_strobe_n : 1'b1;
  assign data = s_data_oe ? s_data :
                (m_data_oe ? m_data : pbt_pkg::PBT_DATA_PULLUP);
  assign ack_n = s_ack_oe ? s_ack_o : 1'b1;
  assign data_error_n = s_data_error_oe ? s_data_error_o : 1'b1;

  modport primary_slave (
    input system_reset_n, secondary_bus_request_n, addr, longword_n, read,
    input sequential_n, lock_n, lower_addr_strobe, upper_addr_strobe_n,
    input upper_byte_strobe_n, lower_byte_strobe_n, data,
    output s_data, s_data_oe, s_ack_o, s_ack_oe, s_data_error_o,
    output s_data_error_oe, secondary_bus_grant_n
  );

  modport secondary_master (
    input system_reset_n, secondary_bus_grant_n, data, ack_n, data_error_n,
    output m_addr, m_longword_n, m_read, m_sequential_n, m_lock_n,
    output m_lower_addr_strobe, m_upper_addr_strobe_n,
    output m_upper_byte_strobe_n, m_lower_byte_strobe_n, m_ctl_oe,
    output m_data, m_data_oe, secondary_bus_request_n
  );
endinterface

// ==== hw/pbt_secondary_master.sv ====
`timescale 1ns/1ns
module pbt_secondary_master #(
  parameter int TIMEOUT_CYCLES = pbt_pkg::PBT_TIMEOUT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  pbt_bus_if.secondary_master bus,
  input wire logic i_start,
  input wire logic i_read,
  input wire logic i_longword,
  input wire logic i_byte,
  input wire logic i_sequential,
  input wire logic i_lock,
  input wire logic i_withdraw,
  input wire logic [23:0] i_addr,
  input wire logic [7:0] i_count,
  input wire logic [31:0] i_wdata,
  output logic o_busy,
  output logic o_granted,
  output logic o_item,
  output logic [31:0] o_rdata,
  output logic o_done,
  output logic o_error,
  output logic o_timeout
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  initial begin
    if (TIMEOUT_CYCLES < 1) begin
      $error("TIMEOUT_CYCLES must be at least 1");
    end
  end

  logic [35:0] sync_a, sync_b;
  logic p_reset_n, p_grant_n, p_ack_n, p_error_n;
  logic [31:0] p_data;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_a <= {pbt_pkg::PBT_MASTER_CTL_IDLE, 32'h0};
      sync_b <= {pbt_pkg::PBT_MASTER_CTL_IDLE, 32'h0};
    end else begin
      sync_a <= {bus.system_reset_n, bus.secondary_bus_grant_n, bus.ack_n,
                 bus.data_error_n, bus.data};
      sync_b <= sync_a;
    end
  end
  assign {p_reset_n, p_grant_n, p_ack_n, p_error_n, p_data} = sync_b;

  pbt_pkg::pbt_master_state_t state, next_state;
  logic req_n, next_req_n, ctl_oe, next_ctl_oe, las, next_las;
  logic uas_n, next_uas_n, ubs_n, next_ubs_n, lbs_n, next_lbs_n;
  logic data_oe, next_data_oe, aborted, next_aborted;
  logic [31:0] data_out, next_data_out, rdata, next_rdata;
  logic [23:0] cur, next_cur;
  logic [7:0] remain, next_remain;
  logic [TW-1:0] timer, next_timer;
  logic lw_n, next_lw_n, rd, next_rd, sq_n, next_sq_n, lk_n, next_lk_n;
  logic bytes, next_bytes, wd, next_wd;
  logic busy, next_busy, granted, next_granted, item, next_item;
  logic done, next_done, err, next_err, tmo, next_tmo;
  logic [23:0] step;
  logic [31:0] lanes_out, lanes_in;

  always_comb begin
    step = !lw_n ? pbt_pkg::PBT_STEP_LONG :
           (bytes ? pbt_pkg::PBT_STEP_BYTE : pbt_pkg::PBT_STEP_WORD);
    if (!lw_n) begin
      lanes_out = i_wdata;
      lanes_in = p_data;
    end else if (!bytes) begin
      lanes_out = {16'h0, i_wdata[15:0]};
      lanes_in = {16'h0, p_data[15:0]};
    end else if (cur[0]) begin
      lanes_out = {24'h0, i_wdata[7:0]};
      lanes_in = {24'h0, p_data[7:0]};
    end else begin
      lanes_out = {16'h0, i_wdata[7:0], 8'h00};
      lanes_in = {24'h0, p_data[15:8]};
    end
  end

  always_comb begin
    next_state = state;
    next_req_n = req_n;
    next_ctl_oe = ctl_oe;
    next_las = las;
    next_uas_n = uas_n;
    next_ubs_n = ubs_n;
    next_lbs_n = lbs_n;
    next_data_oe = data_oe;
    next_data_out = data_out;
    next_aborted = aborted;
    next_rdata = rdata;
    next_cur = cur;
    next_remain = remain;
    next_timer = timer;
    next_lw_n = lw_n;
    next_rd = rd;
    next_sq_n = sq_n;
    next_lk_n = lk_n;
    next_bytes = bytes;
    next_wd = wd;
    next_item = 1'b0;
    next_done = 1'b0;
    next_err = 1'b0;
    next_tmo = 1'b0;
    unique case (state)
      pbt_pkg::PBT_M_IDLE: begin
        if (i_start) begin
          next_req_n = 1'b0;
          next_cur = i_addr;
          next_remain = (i_count == 8'h00) ? 8'h01 : i_count;
          next_lw_n = ~i_longword;
          next_rd = i_read;
          next_sq_n = ~i_sequential;
          next_lk_n = ~i_lock;
          next_bytes = i_byte & ~i_longword;
          next_wd = i_withdraw;
          next_aborted = 1'b0;
          next_state = pbt_pkg::PBT_M_REQ;
        end
      end
      pbt_pkg::PBT_M_REQ: begin
        if (!p_grant_n) begin
          next_ctl_oe = 1'b1;
          next_las = 1'b1;
          next_state = pbt_pkg::PBT_M_LOWER;
        end
      end
      pbt_pkg::PBT_M_LOWER: begin
        if (wd) begin
          next_las = 1'b0;
          next_state = pbt_pkg::PBT_M_FINISH;
        end else begin
          next_uas_n = 1'b0;
          next_ubs_n = bytes & cur[0];
          next_lbs_n = bytes & ~cur[0];
          next_data_oe = ~rd;
          next_data_out = lanes_out;
          next_timer = '0;
          next_state = pbt_pkg::PBT_M_STROBE;
        end
      end
      pbt_pkg::PBT_M_STROBE: begin
        next_timer = timer + 1'b1;
        if (!p_error_n) begin
          next_aborted = 1'b1;
          next_state = pbt_pkg::PBT_M_RELEASE;
        end else if (!p_ack_n) begin
          next_rdata = lanes_in;
          next_state = pbt_pkg::PBT_M_RELEASE;
        end else if (timer == TW'(TIMEOUT_CYCLES - 1)) begin
          next_tmo = 1'b1;
          next_aborted = 1'b1;
          next_state = pbt_pkg::PBT_M_FINISH;
        end
        if (next_state != pbt_pkg::PBT_M_STROBE) begin
          next_ubs_n = 1'b1;
          next_lbs_n = 1'b1;
          next_data_oe = 1'b0;
        end
      end
      pbt_pkg::PBT_M_RELEASE: begin
        // A late abort shows up while the answer is still held
        if (!p_error_n) begin
          next_aborted = 1'b1;
        end
        if (p_ack_n && p_error_n) begin
          next_item = ~aborted;
          if (!aborted && !sq_n && remain > 8'h01) begin
            next_remain = remain - 8'h01;
            next_cur = cur + step;
            next_state = pbt_pkg::PBT_M_LOWER;
          end else begin
            next_state = pbt_pkg::PBT_M_FINISH;
          end
        end
      end
      pbt_pkg::PBT_M_FINISH: begin
        next_las = 1'b0;
        next_uas_n = 1'b1;
        next_ubs_n = 1'b1;
        next_lbs_n = 1'b1;
        next_data_oe = 1'b0;
        next_err = aborted & ~tmo;
        next_state = pbt_pkg::PBT_M_DROP;
      end
      pbt_pkg::PBT_M_DROP: begin
        // Drivers float a cycle before the request goes high
        next_ctl_oe = 1'b0;
        if (!ctl_oe) begin
          next_req_n = 1'b1;
          next_done = 1'b1;
          next_state = pbt_pkg::PBT_M_IDLE;
        end
      end
      default: next_state = pbt_pkg::PBT_M_IDLE;
    endcase
    if (!p_reset_n) begin
      next_state = pbt_pkg::PBT_M_IDLE;
      next_req_n = pbt_pkg::PBT_REQUEST_RESET;
      next_ctl_oe = 1'b0;
      next_las = 1'b0;
      next_uas_n = 1'b1;
      next_ubs_n = 1'b1;
      next_lbs_n = 1'b1;
      next_data_oe = 1'b0;
    end
    next_busy = next_state != pbt_pkg::PBT_M_IDLE;
    next_granted = ~p_grant_n & ~next_req_n;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= pbt_pkg::PBT_M_IDLE;
      req_n <= pbt_pkg::PBT_REQUEST_RESET;
      ctl_oe <= 1'b0;
      las <= 1'b0;
      uas_n <= 1'b1;
      ubs_n <= 1'b1;
      lbs_n <= 1'b1;
      data_oe <= 1'b0;
      data_out <= 32'h0;
      aborted <= 1'b0;
      rdata <= 32'h0;
      cur <= 24'h0;
      remain <= 8'h0;
      timer <= '0;
      lw_n <= 1'b1;
      rd <= 1'b1;
      sq_n <= 1'b1;
      lk_n <= 1'b1;
      bytes <= 1'b0;
      wd <= 1'b0;
      busy <= 1'b0;
      granted <= 1'b0;
      item <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      tmo <= 1'b0;
    end else begin
      state <= next_state;
      req_n <= next_req_n;
      ctl_oe <= next_ctl_oe;
      las <= next_las;
      uas_n <= next_uas_n;
      ubs_n <= next_ubs_n;
      lbs_n <= next_lbs_n;
      data_oe <= next_data_oe;
      data_out <= next_data_out;
      aborted <= next_aborted;
      rdata <= next_rdata;
      cur <= next_cur;
      remain <= next_remain;
      timer <= next_timer;
      lw_n <= next_lw_n;
      rd <= next_rd;
      sq_n <= next_sq_n;
      lk_n <= next_lk_n;
      bytes <= next_bytes;
      wd <= next_wd;
      busy <= next_busy;
      granted <= next_granted;
      item <= next_item;
      done <= next_done;
      err <= next_err;
      tmo <= next_tmo;
    end
  end

  assign bus.m_addr = cur[23:1];
  assign bus.m_longword_n = lw_n;
  assign bus.m_read = rd;
  assign bus.m_sequential_n = sq_n;
  assign bus.m_lock_n = lk_n;
  assign bus.m_lower_addr_strobe = las;
  assign bus.m_upper_addr_strobe_n = uas_n;
  assign bus.m_upper_byte_strobe_n = ubs_n;
  assign bus.m_lower_byte_strobe_n = lbs_n;
  assign bus.m_ctl_oe = ctl_oe;
  assign bus.m_data = data_out;
  assign bus.m_data_oe = data_oe;
  assign bus.secondary_bus_request_n = req_n;
  assign o_busy = busy;
  assign o_granted = granted;
  assign o_item = item;
  assign o_rdata = rdata;
  assign o_done = done;
  assign o_error = err;
  assign o_timeout = tmo;
endmodule

// ==== hw/pbt_primary_slave.sv ====
`timescale 1ns/1ns
// Behaviour
// - Odd bytes travel on lanes 7..0
// - Even bytes travel on lanes 15..8
// - Longword master uses all 32 lanes
// - Words always on low lanes, upper half routed
// - Byte and word access everywhere, longword only if LONGWORD_CAPABLE
// - Narrow slave refuses longword with data error
// - Burst latches start, steps after each item
// - Step lands on next memory location
// - Non-burst slave refuses burst with error
// - Locked multi-address cycles always supported
// - Lock blocks second port until cycle ends
// - Parity fault after answer gives late abort
// - Master timer ends unanswered cycles
// - Withdrawn cycles after lower address tolerated
// - One primary, one secondary per bus
// - Secondary drives request low to use bus
// - Primary grants only after own use ends
// - Grant high during reset until request
// - Request high during reset until release
// - Bus stays secondary while request held low
// - Secondary floats drivers, then request high
// - Upper strobe even, lower odd, both word
module pbt_primary_slave #(
  parameter bit LONGWORD_CAPABLE = 1'b1,
  parameter bit SEQUENTIAL_CAPABLE = 1'b1,
  parameter int DEPTH = pbt_pkg::PBT_MEM_DEPTH,
  parameter logic [21-$clog2(DEPTH):0] BASE_PAGE = '0
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  pbt_bus_if.primary_slave bus,
  input wire logic i_primary_busy,
  input wire logic i_port2_req,
  input wire logic i_port2_write,
  input wire logic [$clog2(DEPTH)-1:0] i_port2_index,
  input wire logic [31:0] i_port2_wdata,
  input wire logic i_inject_parity_error,
  output logic o_port2_ack,
  output logic [31:0] o_port2_rdata,
  output logic o_port2_locked,
  output logic o_primary_owns
);
  localparam int IW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << IW) != DEPTH || IW > 21) begin
      $error("DEPTH must be a power of two from 2 to 2**21");
    end
  end

  // Every pin is synchronised; data and strobes see equal delay
  logic [64:0] sync_a, sync_b;
  logic p_reset_n, p_req_n, p_las, p_uas_n, p_ubs_n, p_lbs_n;
  logic p_lw_n, p_read, p_sq_n, p_lock_n;
  logic [23:1] p_addr;
  logic [31:0] p_data;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_a <= {pbt_pkg::PBT_SLAVE_CTL_IDLE, 55'h0};
      sync_b <= {pbt_pkg::PBT_SLAVE_CTL_IDLE, 55'h0};
    end else begin
      sync_a <= {bus.system_reset_n, bus.secondary_bus_request_n,
                 bus.lower_addr_strobe, bus.upper_addr_strobe_n,
                 bus.upper_byte_strobe_n, bus.lower_byte_strobe_n,
                 bus.longword_n, bus.read, bus.sequential_n, bus.lock_n,
                 bus.addr, bus.data};
      sync_b <= sync_a;
    end
  end
  assign {p_reset_n, p_req_n, p_las, p_uas_n, p_ubs_n, p_lbs_n, p_lw_n,
          p_read, p_sq_n, p_lock_n, p_addr, p_data} = sync_b;

  logic [31:0] mem [DEPTH];
  logic par [DEPTH];

  pbt_pkg::pbt_slave_state_t state, next_state;
  logic ack, next_ack, err, next_err, doe, next_doe, late, next_late;
  logic first, next_first, locked, next_locked;
  logic [31:0] dout, next_dout, p2_rdata, next_p2_rdata;
  logic [23:0] burst, next_burst;
  logic p2_ack, next_p2_ack, grant_n, next_grant_n, owns, next_owns;
  logic [23:0] acc, step;
  logic [IW-1:0] idx, mem_idx;
  logic [31:0] word, rd, wr, mem_wdata;
  logic [15:0] half;
  logic strobe_on, hit, refuse, mem_we;

  always_comb begin
    // Burst items after the first take the internal counter
    acc = (!p_sq_n && !first) ? burst : {p_addr, p_ubs_n & ~p_lbs_n};
    hit = acc[23:IW+2] == BASE_PAGE;
    idx = acc[IW+1:2];
    word = mem[idx];
    half = acc[1] ? word[15:0] : word[31:16];
    strobe_on = ~p_ubs_n | ~p_lbs_n;
    refuse = (!p_lw_n && !LONGWORD_CAPABLE)
             || (!p_sq_n && !SEQUENTIAL_CAPABLE);
    if (!p_lw_n) begin
      step = pbt_pkg::PBT_STEP_LONG;
      rd = word;
      wr = p_data;
    end else begin
      step = (!p_ubs_n && !p_lbs_n) ? pbt_pkg::PBT_STEP_WORD
                                    : pbt_pkg::PBT_STEP_BYTE;
      rd = {16'h0, p_ubs_n ? 8'h00 : half[15:8],
            p_lbs_n ? 8'h00 : half[7:0]};
      if (acc[1]) begin
        wr = {word[31:16], p_ubs_n ? word[15:8] : p_data[15:8],
              p_lbs_n ? word[7:0] : p_data[7:0]};
      end else begin
        wr = {p_ubs_n ? word[31:24] : p_data[15:8],
              p_lbs_n ? word[23:16] : p_data[7:0], word[15:0]};
      end
    end
  end

  always_comb begin
    next_state = state;
    next_ack = ack;
    next_err = err;
    next_doe = doe;
    next_late = late;
    next_first = first;
    next_locked = locked;
    next_dout = dout;
    next_burst = burst;
    next_p2_ack = 1'b0;
    next_p2_rdata = p2_rdata;
    mem_we = 1'b0;
    mem_idx = idx;
    mem_wdata = wr;
    unique case (state)
      pbt_pkg::PBT_SL_IDLE: begin
        next_first = 1'b1;
        next_locked = locked & ~p_lock_n;
        if (p_las) begin
          next_state = pbt_pkg::PBT_SL_ADDR;
        end else if (i_port2_req && !locked && !p2_ack) begin
          next_p2_ack = 1'b1;
          next_p2_rdata = mem[i_port2_index];
          mem_we = i_port2_write;
          mem_idx = i_port2_index;
          mem_wdata = i_port2_wdata;
        end
      end
      pbt_pkg::PBT_SL_ADDR: begin
        if (!p_las && p_uas_n) begin
          next_state = pbt_pkg::PBT_SL_IDLE;
        end else if (!p_uas_n && strobe_on && hit) begin
          next_state = pbt_pkg::PBT_SL_RESP;
          if (refuse) begin
            next_err = 1'b1;
          end else begin
            next_ack = 1'b1;
            next_first = 1'b0;
            next_burst = acc + step;
            next_locked = locked | ~p_lock_n;
            if (p_read) begin
              next_dout = rd;
              next_doe = 1'b1;
              next_late = (^word) != par[idx];
            end else begin
              mem_we = 1'b1;
            end
          end
        end
      end
      pbt_pkg::PBT_SL_RESP: begin
        // Late abort: error joins the answer one cycle after it
        if (late) begin
          next_err = 1'b1;
        end
        if (!strobe_on) begin
          next_ack = 1'b0;
          next_err = 1'b0;
          next_doe = 1'b0;
          next_late = 1'b0;
          next_state = pbt_pkg::PBT_SL_HOLD;
        end
      end
      pbt_pkg::PBT_SL_HOLD: begin
        next_state = (p_uas_n && !p_las) ? pbt_pkg::PBT_SL_IDLE
                                         : pbt_pkg::PBT_SL_ADDR;
      end
    endcase
    if (!p_reset_n) begin
      next_state = pbt_pkg::PBT_SL_IDLE;
      next_ack = 1'b0;
      next_err = 1'b0;
      next_doe = 1'b0;
      next_late = 1'b0;
      next_locked = 1'b0;
    end
  end

  always_comb begin
    next_grant_n = grant_n;
    if (!p_reset_n) begin
      next_grant_n = pbt_pkg::PBT_GRANT_RESET;
    end else if (grant_n && !p_req_n && !i_primary_busy) begin
      next_grant_n = 1'b0;
    end else if (!grant_n && p_req_n) begin
      next_grant_n = 1'b1;
    end
    // Held low for as long as the request stays low
    next_owns = next_grant_n;
  end

  // Storage has no reset; parity makes uninitialised reads detectable
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wdata;
      par[mem_idx] <= (^mem_wdata) ^ i_inject_parity_error;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= pbt_pkg::PBT_SL_IDLE;
      ack <= 1'b0;
      err <= 1'b0;
      doe <= 1'b0;
      late <= 1'b0;
      first <= 1'b1;
      locked <= 1'b0;
      dout <= 32'h0;
      burst <= 24'h0;
      p2_ack <= 1'b0;
      p2_rdata <= 32'h0;
      grant_n <= pbt_pkg::PBT_GRANT_RESET;
      owns <= 1'b1;
    end else begin
      state <= next_state;
      ack <= next_ack;
      err <= next_err;
      doe <= next_doe;
      late <= next_late;
      first <= next_first;
      locked <= next_locked;
      dout <= next_dout;
      burst <= next_burst;
      p2_ack <= next_p2_ack;
      p2_rdata <= next_p2_rdata;
      grant_n <= next_grant_n;
      owns <= next_owns;
    end
  end

  assign bus.s_data = dout;
  assign bus.s_data_oe = doe;
  assign bus.s_ack_o = 1'b0;
  assign bus.s_ack_oe = ack;
  assign bus.s_data_error_o = 1'b0;
  assign bus.s_data_error_oe = err;
  assign bus.secondary_bus_grant_n = grant_n;
  assign o_port2_ack = p2_ack;
  assign o_port2_rdata = p2_rdata;
  assign o_port2_locked = locked;
  assign o_primary_owns = owns;
endmodule

// ==== tb/pbt_assertions.sv ====
`timescale 1ns/1ns
module pbt_assertions (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic system_reset_n,
  input wire logic secondary_bus_request_n,
  input wire logic secondary_bus_grant_n,
  input wire logic m_ctl_oe,
  input wire logic m_data_oe,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic [23:1] addr,
  input wire logic ack_n,
  input wire logic data_error_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  AST_GRANT_NEEDS_REQ: assert property (
    $fell(secondary_bus_grant_n) |-> !secondary_bus_request_n)
    else $error("grant given without request");
  AST_GRANT_IN_RESET: assert property (
    !system_reset_n [*4] |-> secondary_bus_grant_n)
    else $error("grant low during system reset");
  AST_REQ_IN_RESET: assert property (
    !system_reset_n [*4] |-> secondary_bus_request_n)
    else $error("request low during system reset");
  AST_BUS_ONLY_GRANTED: assert property (
    m_ctl_oe |-> !secondary_bus_grant_n)
    else $error("master drives bus without grant");
  AST_HOLD_GRANT: assert property (
    disable iff (!i_resetn || !system_reset_n)
    !secondary_bus_grant_n && !secondary_bus_request_n
    |=> !secondary_bus_grant_n)
    else $error("grant taken back while request held");
  AST_FLOAT_FIRST: assert property (
    $rose(secondary_bus_request_n) |-> !m_ctl_oe && !m_data_oe
    && !$past(m_ctl_oe))
    else $error("request released before drivers floated");
  AST_GRANT_RETURN: assert property (
    $rose(secondary_bus_request_n) |-> ##[1:5] secondary_bus_grant_n)
    else $error("grant not returned high");
  AST_ANSWER: assert property (
    $fell(upper_byte_strobe_n && lower_byte_strobe_n)
    && addr[23:12] == 12'h000 |-> ##[1:5] (!ack_n || !data_error_n))
    else $error("no answer to strobe");
  AST_LATE_ABORT: assert property (
    $fell(data_error_n) && !ack_n |-> !$past(ack_n))
    else $error("late abort without earlier acknowledge");
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic st = 1'b0, rd = 1'b0, lw = 1'b0, by = 1'b0, sq = 1'b0;
  logic lk = 1'b0, wd = 1'b0, pb = 1'b0, p2 = 1'b0, inj = 1'b0;
  logic [23:0] ad = 24'h0;
  logic [7:0] cnt = 8'h0;
  logic [31:0] wdat = 32'h0, rdata, p2rd;
  logic busy, gnt, item, done, err, tmo, p2ack, p2lk, owns;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  int nerr = 0, ntmo = 0, nl = 0, nlk = 0, nd = 0;
  logic [31:0] q[$];
  logic [23:0] ta[5] = '{24'h200, 24'h202, 24'h200, 24'h203, 24'h200};
  logic [1:0] tk[5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
  logic [31:0] te[5] = '{32'haabb, 32'hccdd, 32'haa, 32'hdd, 32'haabbccdd};
  pbt_bus_if bus ();
  pbt_secondary_master #(.TIMEOUT_CYCLES(20)) pbt_secondary_master_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .bus(bus), .i_start(st),
    .i_read(rd), .i_longword(lw), .i_byte(by), .i_sequential(sq),
    .i_lock(lk), .i_withdraw(wd), .i_addr(ad), .i_count(cnt),
    .i_wdata(wdat), .o_busy(busy), .o_granted(gnt), .o_item(item),
    .o_rdata(rdata), .o_done(done), .o_error(err), .o_timeout(tmo));
  pbt_primary_slave pbt_primary_slave_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .bus(bus), .i_primary_busy(pb),
    .i_port2_req(p2), .i_port2_write(1'b0), .i_port2_index(10'hc0),
    .i_port2_wdata(32'h0), .i_inject_parity_error(inj),
    .o_port2_ack(p2ack), .o_port2_rdata(p2rd), .o_port2_locked(p2lk),
    .o_primary_owns(owns));
  pbt_assertions pbt_assertions_i (
    .i_clk(i_clk), .i_resetn(i_resetn),
    .system_reset_n(bus.system_reset_n),
    .secondary_bus_request_n(bus.secondary_bus_request_n),
    .secondary_bus_grant_n(bus.secondary_bus_grant_n),
    .m_ctl_oe(bus.m_ctl_oe), .m_data_oe(bus.m_data_oe),
    .upper_byte_strobe_n(bus.upper_byte_strobe_n),
    .lower_byte_strobe_n(bus.lower_byte_strobe_n), .addr(bus.addr),
    .ack_n(bus.ack_n), .data_error_n(bus.data_error_n));
  always #5 i_clk = ~i_clk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (item) q.push_back(rdata);
    if (err) nerr++;
    if (tmo) ntmo++;
    if (done) nd++;
    if (p2lk) nl++;
    if (p2ack && p2lk) nlk++;
    // Ceiling well above the under one thousand cycles the tests need
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Kind k: 0 word, 1 byte, 2 longword
  task automatic xf(input logic r, input logic [1:0] k, input logic s,
                    input logic l, input logic w, input logic [23:0] a,
                    input logic [7:0] n, input logic [31:0] d);
    int i;
    @(negedge i_clk);
    {rd, by, lw, sq, lk, wd} = {r, k[0], k[1], s, l, w};
    ad = a;
    cnt = n;
    wdat = d;
    q.delete();
    nerr = 0;
    ntmo = 0;
    nd = 0;
    st = 1'b1;
    @(negedge i_clk);
    st = 1'b0;
    i = 0;
    while (busy !== 1'b0 && i < 2000) begin
      @(negedge i_clk);
      i++;
    end
    // Let the grant return before the next request
    repeat (8) @(negedge i_clk);
  endtask
  initial begin
    bus.system_reset_n = 1'b0;
    repeat (3) @(negedge i_clk);
    i_resetn = 1'b1;
    repeat (5) @(negedge i_clk);
    chk(32'(owns), 32'h1);
    bus.system_reset_n = 1'b1;
    repeat (5) @(negedge i_clk);
    xf(0, 0, 0, 0, 0, 24'h100, 0, 32'h1234);
    xf(0, 1, 0, 0, 0, 24'h101, 0, 32'h77);
    xf(1, 0, 0, 0, 0, 24'h100, 0, 0);
    chk(q[0], 32'h1277);
    xf(0, 2, 0, 0, 0, 24'h200, 0, 32'haabbccdd);
    for (int i = 0; i < 5; i++) begin
      xf(1, tk[i], 0, 0, 0, ta[i], 0, 0);
      chk(q[0], te[i]);
    end
    $display("lane test done");
    for (int i = 0; i < 3; i++) xf(0, 0, 0, 0, 0, 24'h300 + 24'(2 * i), 0,
                                  32'(i + 1));
    xf(1, 0, 1, 0, 0, 24'h300, 3, 0);
    for (int i = 0; i < 3; i++) chk(q[i], 32'(i + 1));
    xf(0, 2, 1, 0, 0, 24'h500, 2, 32'hc0de0001);
    xf(1, 2, 0, 0, 0, 24'h504, 0, 0);
    chk(q[0], 32'hc0de0001);
    $display("burst test done");
    p2 = 1'b1;
    xf(1, 0, 1, 1, 0, 24'h300, 3, 0);
    p2 = 1'b0;
    chk(32'(nl != 0), 32'h1);
    chk(32'(nlk), 32'h0);
    chk(p2rd, 32'h00010002);
    $display("lock test done");
    inj = 1'b1;
    xf(0, 2, 0, 0, 0, 24'h400, 0, 32'h5a5a);
    inj = 1'b0;
    xf(1, 0, 0, 0, 0, 24'h400, 0, 0);
    chk(32'(nerr), 32'h1);
    xf(1, 0, 0, 0, 1, 24'h100, 0, 0);
    chk(32'(q.size()) + 32'(nerr + ntmo), 32'h0);
    chk(32'(nd), 32'h1);
    xf(1, 0, 0, 0, 0, 24'h800000, 0, 0);
    chk(32'(ntmo), 32'h1);
    $display("error test done");
    pb = 1'b1;
    fork
      xf(1, 0, 0, 0, 0, 24'h100, 0, 0);
      begin
        repeat (30) @(negedge i_clk);
        chk({30'h0, gnt, owns}, 32'h1);
        pb = 1'b0;
      end
    join
    chk(q[0], 32'h1277);
    $display("arbitration test done");
    wrap_up();
  end
endmodule
